// ### common/fsr_pkg.sv
// Purpose: constants and types for the flash suspend/resume/reset control
// Assumes: 250 MHz system clock, SPI mode 0 framing on the link pins
// Notes:   classes on cmd come from the surrounding opcode decoder
package fsr_pkg;

   localparam int SEC_W = 10;
   localparam int PG_W  = 8;

   // opcode values of the reset pair
   localparam logic [7:0] OPC_RST_EN  = 8'h66;
   localparam logic [7:0] OPC_RST_MEM = 8'h99;
   localparam logic [3:0] FRAME_BITS  = 4'h8;

   // flag byte layout and reset value
   localparam int         FL_PEC      = 7;
   localparam int         FL_ERS_SUSP = 6;
   localparam int         FL_PRG_ERR  = 4;
   localparam int         FL_PRG_SUSP = 2;
   localparam logic [7:0] FLAG_RST    = 8'h80;

   // suspend latencies
   localparam int          CLK_MHZ          = 250;
   localparam int          PRG_SUSP_LAT_US  = 7;
   localparam int          ERS_SUSP_LAT_US  = 15;
   localparam logic [11:0] PRG_SUSP_CYC = 12'(PRG_SUSP_LAT_US * CLK_MHZ);
   localparam logic [11:0] ERS_SUSP_CYC = 12'(ERS_SUSP_LAT_US * CLK_MHZ);

   typedef enum logic [3:0] {
      ST_STANDBY = 4'h1,
      ST_BUSY    = 4'h2,
      ST_PSUSP   = 4'h4,
      ST_ESUSP   = 4'h8
   } fsr_state_t;

   typedef enum logic [3:0] {
      CL_READ   = 4'h0, // array reads
      CL_PROG   = 4'h1, // page programs
      CL_SERASE = 4'h2, // sector erase
      CL_SSE    = 4'h3, // subsector erase
      CL_WREG   = 4'h4, // status or nonvolatile config write
      CL_WNV    = 4'h5, // otp program, die erase
      CL_WVOL   = 4'h6, // volatile writes, enables, address, lock
      CL_CLRFL  = 4'h7, // clear flag status
      CL_RDSR   = 4'h8, // status or flag status read
      CL_SUSP   = 4'h9,
      CL_RESUME = 4'ha,
      CL_OTHER  = 4'hb
   } fsr_cls_t;

   typedef enum logic [2:0] {
      OP_PROG  = 3'h0,
      OP_ERASE = 3'h1,
      OP_SSE   = 3'h2,
      OP_WREG  = 3'h3,
      OP_WNV   = 3'h4
   } fsr_kind_t;

   typedef struct packed {
      fsr_cls_t         cls;
      logic [SEC_W-1:0] sector;
      logic [PG_W-1:0]  page;
   } fsr_cmd_t;

   typedef struct packed {
      fsr_kind_t        kind;
      logic [SEC_W-1:0] sector;
      logic [PG_W-1:0]  page;
      logic             resumed; // skip lock check on restart
   } fsr_op_t;

endpackage : fsr_pkg

// ### design/fsr_ctrl.sv
// Purpose: device state, command acceptance, suspend/resume, software reset
// Assumes: cmd_valid_i from the opcode decoder on sys_clk_i
// Notes:   link pins are sampled through two flip-flops each
`timescale 1ns/1ns
module fsr_ctrl
   import fsr_pkg::*;
(
   input  wire logic       sys_clk_i,
   input  wire logic       rst_n_i,
   input  wire logic       cs_n_i,
   input  wire logic       sclk_i,
   input  wire logic       serial_in_line_i,
   input  wire logic       cmd_valid_i,
   input  wire fsr_cmd_t   cmd_i,
   input  wire logic       op_done_i,
   output logic            cmd_accept_o,
   output logic            cmd_reject_o,
   output logic            rd_unsure_o,
   output logic            go_o,
   output fsr_op_t         op_o,
   output logic            susp_req_o,
   output logic            abort_o,
   output logic            sw_reset_o,
   output logic            wip_o,
   output logic [7:0]      flags_o,
   output fsr_state_t      state_o
);

   // pin synchronisers: bit 0 cs, bit 1 clock, bit 2 data
   logic [2:0]       sync1_r;
   logic [2:0]       sync2_r;
   logic             cs_d_r;
   logic             sclk_d_r;
   logic [7:0]       shift_r;
   logic [3:0]       bitcnt_r;
   logic             arm_r;
   logic             arm_nxt;

   fsr_state_t       state_r;
   fsr_state_t       state_nxt;
   logic [7:0]       flags_r;
   logic [7:0]       flags_nxt;
   fsr_op_t          op_r;
   fsr_op_t          op_nxt;
   fsr_op_t          rin_r;
   fsr_op_t          rin_nxt;
   logic             rin_v_r;
   logic             rin_v_nxt;
   logic [SEC_W-1:0] rers_sec_r;
   logic [SEC_W-1:0] rers_sec_nxt;
   logic             rers_v_r;
   logic             rers_v_nxt;
   logic             pend_r;
   logic             pend_nxt;
   logic [11:0]      lat_r;
   logic [11:0]      lat_nxt;
   logic             go_nxt;
   logic             susp_nxt;
   logic             abort_nxt;

   // link edge detection
   wire cs_s      = sync2_r[0];
   wire cs_rise   = cs_s & ~cs_d_r;
   wire cs_fall   = ~cs_s & cs_d_r;
   wire sclk_rise = sync2_r[1] & ~sclk_d_r;
   wire byte_ok   = bitcnt_r == FRAME_BITS;

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sync1_r  <= 3'h1;
         sync2_r  <= 3'h1;
         cs_d_r   <= 1'b1;
         sclk_d_r <= 1'b0;
      end else begin
         sync1_r  <= {serial_in_line_i, sclk_i, cs_n_i};
         sync2_r  <= sync1_r;
         cs_d_r   <= cs_s;
         sclk_d_r <= sync2_r[1];
      end
   end

   // frame shifter, counts bits up to one past a byte
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         shift_r  <= 8'h00;
         bitcnt_r <= 4'h0;
      end else if (cs_fall) begin
         bitcnt_r <= 4'h0;
      end else if (!cs_s && sclk_rise) begin
         shift_r  <= {shift_r[6:0], sync2_r[2]};
         bitcnt_r <= byte_ok ? 4'h9 : (bitcnt_r == 4'h9 ? 4'h9
                                       : bitcnt_r + 4'h1);
      end
   end

   // state and command decode
   wire st_stby  = state_r == ST_STANDBY;
   wire st_busy  = state_r == ST_BUSY;
   wire st_psusp = state_r == ST_PSUSP;
   wire st_esusp = state_r == ST_ESUSP;
   wire st_susp  = st_psusp | st_esusp;
   wire is_read  = cmd_i.cls == CL_READ;
   wire is_prog  = cmd_i.cls == CL_PROG;
   wire is_ers   = cmd_i.cls == CL_SERASE;
   wire is_sse   = cmd_i.cls == CL_SSE;
   wire is_wreg  = cmd_i.cls == CL_WREG;
   wire is_wnv   = cmd_i.cls == CL_WNV;
   wire is_wvol  = cmd_i.cls == CL_WVOL;
   wire is_clrfl = cmd_i.cls == CL_CLRFL;
   wire is_rdsr  = cmd_i.cls == CL_RDSR;
   wire is_susp  = cmd_i.cls == CL_SUSP;
   wire is_res   = cmd_i.cls == CL_RESUME;
   wire is_other = cmd_i.cls == CL_OTHER;
   wire hit_esec = rers_v_r & (cmd_i.sector == rers_sec_r);
   wire hit_ppg  = rin_v_r & (cmd_i.sector == rin_r.sector)
                   & (rin_r.kind == OP_SSE | cmd_i.page == rin_r.page);
   wire op_susp  = op_r.kind inside {OP_PROG, OP_ERASE, OP_SSE};

   // acceptance per state
   wire a_read  = is_read & ~st_busy;
   wire a_prog  = is_prog & (st_stby | (st_esusp & ~hit_esec));
   wire a_ers   = (is_ers | is_sse | is_wreg | is_wnv) & st_stby;
   wire a_vol   = (is_wvol | is_clrfl | is_other) & ~st_busy;
   wire a_rdsr  = is_rdsr;
   wire a_susp  = is_susp & st_busy & ~pend_r & op_susp;
   wire a_res   = is_res & st_susp;
   wire accept  = cmd_valid_i & (a_read | a_prog | a_ers | a_vol
                                 | a_rdsr | a_susp | a_res);
   wire start   = cmd_valid_i & (a_prog | a_ers);
   wire prg_blk = cmd_valid_i & is_prog & st_esusp & hit_esec;
   wire unsure  = cmd_valid_i & a_read
                  & (hit_esec | (st_psusp & hit_ppg));
   wire clr_fl  = cmd_valid_i & a_vol & is_clrfl;

   // kind of a newly started operation
   wire fsr_kind_t start_kind = is_prog ? OP_PROG :
                                is_ers  ? OP_ERASE :
                                is_sse  ? OP_SSE :
                                is_wreg ? OP_WREG : OP_WNV;

   // reset pair: second frame needs the first armed
   wire wreg_run  = st_busy & (op_r.kind == OP_WREG);
   wire do_reset  = cs_rise & byte_ok & (shift_r == OPC_RST_MEM)
                    & arm_r;
   assign arm_nxt = cs_rise ? (byte_ok & (shift_r == OPC_RST_EN)
                               & ~wreg_run)
                            : arm_r;

   // flag bit cleared when a suspend ends without suspending
   wire [7:0] susp_bit = (op_r.kind == OP_PROG) ? (8'h01 << FL_PRG_SUSP)
                                                : (8'h01 << FL_ERS_SUSP);
   wire [11:0] lat_load = (op_r.kind == OP_PROG) ? PRG_SUSP_CYC - 12'h001
                                                 : ERS_SUSP_CYC - 12'h001;

   // next-state logic
   always_comb begin
      state_nxt    = state_r;
      flags_nxt    = flags_r;
      op_nxt       = op_r;
      rin_nxt      = rin_r;
      rin_v_nxt    = rin_v_r;
      rers_sec_nxt = rers_sec_r;
      rers_v_nxt   = rers_v_r;
      pend_nxt     = pend_r;
      lat_nxt      = (lat_r != 12'h000) ? lat_r - 12'h001 : lat_r;
      go_nxt       = 1'b0;
      susp_nxt     = 1'b0;
      abort_nxt    = 1'b0;
      unique case (state_r)
         ST_STANDBY, ST_PSUSP, ST_ESUSP: begin
            if (start) begin
               state_nxt        = ST_BUSY;
               op_nxt.kind      = start_kind;
               op_nxt.sector    = cmd_i.sector;
               op_nxt.page      = cmd_i.page;
               op_nxt.resumed   = 1'b0;
               go_nxt           = 1'b1;
               flags_nxt[FL_PEC] = 1'b0;
            end else if (cmd_valid_i && a_res) begin
               state_nxt         = ST_BUSY;
               flags_nxt[FL_PEC] = 1'b0;
               go_nxt            = 1'b1;
               if (rin_v_r) begin
                  op_nxt         = rin_r;
                  op_nxt.resumed = 1'b1;
                  rin_v_nxt      = 1'b0;
                  if (rin_r.kind == OP_PROG)
                     flags_nxt[FL_PRG_SUSP] = 1'b0;
                  else
                     flags_nxt[FL_ERS_SUSP] = 1'b0;
               end else begin
                  op_nxt.kind    = OP_ERASE;
                  op_nxt.sector  = rers_sec_r;
                  op_nxt.page    = '0;
                  op_nxt.resumed = 1'b1;
                  rers_v_nxt     = 1'b0;
                  flags_nxt[FL_ERS_SUSP] = 1'b0;
               end
            end
         end
         ST_BUSY: begin
            if (op_done_i) begin
               state_nxt         = rers_v_r ? ST_ESUSP : ST_STANDBY;
               flags_nxt[FL_PEC] = 1'b1;
               pend_nxt          = 1'b0;
               if (pend_r)
                  flags_nxt = flags_nxt & ~susp_bit;
            end else if (pend_r && lat_r == 12'h000) begin
               pend_nxt          = 1'b0;
               flags_nxt[FL_PEC] = 1'b1;
               if (op_r.kind == OP_ERASE) begin
                  state_nxt    = ST_ESUSP;
                  rers_v_nxt   = 1'b1;
                  rers_sec_nxt = op_r.sector;
               end else begin
                  state_nxt = ST_PSUSP;
                  rin_v_nxt = 1'b1;
                  rin_nxt   = op_r;
               end
            end else if (cmd_valid_i && a_susp) begin
               pend_nxt  = 1'b1;
               lat_nxt   = lat_load;
               susp_nxt  = 1'b1;
               flags_nxt = flags_r | susp_bit;
            end
         end
         default: state_nxt = ST_STANDBY;
      endcase
      // error flag: a new refusal wins over a clear
      flags_nxt[FL_PRG_ERR] = (flags_r[FL_PRG_ERR] & ~clr_fl) | prg_blk;
      if (do_reset) begin
         abort_nxt  = ~st_stby;
         state_nxt  = ST_STANDBY;
         flags_nxt  = FLAG_RST;
         rin_v_nxt  = 1'b0;
         rers_v_nxt = 1'b0;
         pend_nxt   = 1'b0;
         go_nxt     = 1'b0;
         susp_nxt   = 1'b0;
      end
   end

   // control registers
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_r    <= ST_STANDBY;
         flags_r    <= FLAG_RST;
         op_r       <= '0;
         rin_r      <= '0;
         rin_v_r    <= 1'b0;
         rers_sec_r <= '0;
         rers_v_r   <= 1'b0;
         pend_r     <= 1'b0;
         lat_r      <= 12'h000;
         arm_r      <= 1'b0;
      end else begin
         state_r    <= state_nxt;
         flags_r    <= flags_nxt;
         op_r       <= op_nxt;
         rin_r      <= rin_nxt;
         rin_v_r    <= rin_v_nxt;
         rers_sec_r <= rers_sec_nxt;
         rers_v_r   <= rers_v_nxt;
         pend_r     <= pend_nxt;
         lat_r      <= lat_nxt;
         arm_r      <= arm_nxt & ~do_reset;
      end
   end

   // registered outputs
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cmd_accept_o <= 1'b0;
         cmd_reject_o <= 1'b0;
         rd_unsure_o  <= 1'b0;
         go_o         <= 1'b0;
         op_o         <= '0;
         susp_req_o   <= 1'b0;
         abort_o      <= 1'b0;
         sw_reset_o   <= 1'b0;
         wip_o        <= 1'b0;
         flags_o      <= FLAG_RST;
         state_o      <= ST_STANDBY;
      end else begin
         cmd_accept_o <= accept;
         cmd_reject_o <= cmd_valid_i & ~accept;
         rd_unsure_o  <= unsure;
         go_o         <= go_nxt;
         op_o         <= op_nxt;
         susp_req_o   <= susp_nxt;
         abort_o      <= abort_nxt;
         sw_reset_o   <= do_reset;
         wip_o        <= state_nxt == ST_BUSY;
         flags_o      <= flags_nxt;
         state_o      <= state_nxt;
      end
   end

endmodule : fsr_ctrl

// ### dv/fsr_ctrl_assertions.sv
// Purpose: port checks for fsr_ctrl
// Assumes: single clock, async low reset
// Notes:   lat_r counts cycles of a pending suspend
`timescale 1ns/1ns
module fsr_ctrl_chk
   import fsr_pkg::*;
(
   input wire logic       sys_clk_i,
   input wire logic       rst_n_i,
   input wire logic       cmd_valid_i,
   input wire fsr_cmd_t   cmd_i,
   input wire logic       op_done_i,
   input wire logic       cmd_accept_o,
   input wire logic       cmd_reject_o,
   input wire logic       go_o,
   input wire fsr_op_t    op_o,
   input wire logic       susp_req_o,
   input wire logic       sw_reset_o,
   input wire logic       wip_o,
   input wire logic [7:0] flags_o,
   input wire fsr_state_t state_o
);
   logic [11:0] lat_r;
   logic [11:0] lat_nxt;
   logic        v;
   fsr_cls_t    c;
   logic [SEC_W-1:0] esec_r;
   // shorthand and latency count from an accepted suspend
   assign v = cmd_valid_i;
   assign c = cmd_i.cls;
   assign lat_nxt = susp_req_o ? 12'h001 :
      (lat_r != 12'h000 && state_o == ST_BUSY) ? lat_r + 12'h001 : 12'h000;
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) lat_r <= 12'h000;
      else lat_r <= lat_nxt;
   end
   // sector of the erase last started or resumed
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) esec_r <= '0;
      else if (go_o && op_o.kind == OP_ERASE) esec_r <= op_o.sector;
   end
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);
   AST_ANSWER: assert property (v |=> cmd_accept_o != cmd_reject_o)
      else $error("command answer missing or doubled");
   AST_BUSY_ONLY: assert property (v && state_o == ST_BUSY && !op_done_i
      && !(c inside {CL_RDSR, CL_SUSP}) |=> cmd_reject_o)
      else $error("busy state took a refused command");
   AST_ESUSP_NO: assert property (v && state_o == ST_ESUSP && c inside
      {CL_SERASE, CL_SSE, CL_WREG, CL_WNV} |=> cmd_reject_o && !go_o)
      else $error("erase suspend took a refused command");
   AST_PROG_HIT: assert property (v && state_o == ST_ESUSP
      && c == CL_PROG && cmd_i.sector == esec_r
      |=> cmd_reject_o && flags_o[FL_PRG_ERR])
      else $error("program to suspended sector not flagged");
   AST_PROG_MISS: assert property (v && state_o == ST_ESUSP
      && c == CL_PROG && cmd_i.sector != esec_r
      |=> cmd_accept_o && go_o)
      else $error("program to other sector not started");
   AST_SUSP_IDLE: assert property (v && c == CL_SUSP && state_o != ST_BUSY
      |=> !susp_req_o && $stable(flags_o))
      else $error("suspend outside busy had an effect");
   AST_RES_IDLE: assert property (v && c == CL_RESUME && state_o == ST_STANDBY
      |=> cmd_reject_o && !go_o && $stable(flags_o))
      else $error("resume in standby had an effect");
   AST_RES_GO: assert property (v && c == CL_RESUME && state_o != ST_BUSY
      && state_o != ST_STANDBY |=> go_o && op_o.resumed && wip_o
      && !flags_o[FL_PEC] && state_o == ST_BUSY)
      else $error("resume did not restart work");
   AST_SUSP_LAT: assert property ($past(state_o) == ST_BUSY
      && state_o inside {ST_PSUSP, ST_ESUSP} && !$past(op_done_i)
      && lat_r != 12'h000 |-> flags_o[FL_PEC] && lat_r ==
      (op_o.kind == OP_PROG ? PRG_SUSP_CYC : ERS_SUSP_CYC))
      else $error("suspend latency wrong");
   AST_SUSP_FLAG: assert property (susp_req_o && op_o.kind == OP_PROG
      |-> flags_o[FL_PRG_SUSP] && !flags_o[FL_PEC])
      else $error("program suspend flag not set");
   AST_DONE: assert property (op_done_i && state_o == ST_BUSY |=>
      flags_o[FL_PEC] && !wip_o && !flags_o[FL_PRG_SUSP])
      else $error("completion not reported");
   AST_SWRESET: assert property (sw_reset_o |-> flags_o == FLAG_RST
      && state_o == ST_STANDBY && !wip_o)
      else $error("software reset left state behind");
   COV_SUSP: cover property (susp_req_o);
   COV_RESET: cover property (sw_reset_o);
   COV_NEST: cover property (v && c == CL_RESUME && state_o == ST_PSUSP);
endmodule : fsr_ctrl_chk

bind fsr_ctrl fsr_ctrl_chk u_chk (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
   .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .op_done_i(op_done_i),
   .cmd_accept_o(cmd_accept_o), .cmd_reject_o(cmd_reject_o), .go_o(go_o),
   .op_o(op_o), .susp_req_o(susp_req_o), .sw_reset_o(sw_reset_o),
   .wip_o(wip_o), .flags_o(flags_o), .state_o(state_o));

// ### dv/fsr_host_model.sv
// Purpose: link host sending reset command frames
// Assumes: mode 0 framing, 80 ns serial clock
// Notes:   clock stands still between frames
`timescale 1ns/1ns
module fsr_host_model #(
   parameter int RESET_GAP_TIME      = 200, // ns
   parameter int RESET_RECOVERY_TIME = 400  // ns
) (
   output logic cs_n_o,
   output logic sclk_o,
   output logic sdo_o
);
   initial begin
      cs_n_o = 1'b1;
      sclk_o = 1'b0;
      sdo_o = 1'b0;
   end
   // one 8-bit frame, msb first
   task automatic frame(input logic [7:0] b);
      cs_n_o = 1'b0;
      for (int i = 7; i >= 0; i--) begin
         sdo_o = b[i];
         #40 sclk_o = 1'b1;
         #40 sclk_o = 1'b0;
      end
      #40 cs_n_o = 1'b1;
      sdo_o = ~sdo_o; // released line shows no stale bit
   endtask : frame
   // enable frame, gap, second frame, recovery
   task automatic reset_pair(input logic [7:0] second);
      frame(8'h66);
      #(RESET_GAP_TIME);
      frame(second);
      #(RESET_RECOVERY_TIME);
   endtask : reset_pair
endmodule : fsr_host_model

// ### dv/flash_suspend_resume_reset_tb.sv
// Purpose: scenario bench for fsr_ctrl
// Assumes: inputs change on falling clock edges
// Notes:   suspend latencies are run at full length
`timescale 1ns/1ns
module flash_suspend_resume_reset_tb
   import fsr_pkg::*;
;
   logic clk, rst_n, cmd_valid, op_done, acc, rej, unsure, go, susp, abrt;
   logic swr, wip, cs_n, sclk, sdo;
   fsr_cmd_t   cmd;
   fsr_op_t    op;
   logic [7:0] flags;
   fsr_state_t state;
   int         n_fail, checks_done, n_swr, n_abt, n;
   fsr_ctrl u_dut (.sys_clk_i(clk), .rst_n_i(rst_n), .cs_n_i(cs_n),
      .sclk_i(sclk), .serial_in_line_i(sdo), .cmd_valid_i(cmd_valid),
      .cmd_i(cmd), .op_done_i(op_done), .cmd_accept_o(acc),
      .cmd_reject_o(rej), .rd_unsure_o(unsure), .go_o(go), .op_o(op),
      .susp_req_o(susp), .abort_o(abrt), .sw_reset_o(swr), .wip_o(wip),
      .flags_o(flags), .state_o(state));
   fsr_host_model u_host (.cs_n_o(cs_n), .sclk_o(sclk), .sdo_o(sdo));
   // clock and reset pulse counters
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk) begin
      if (swr === 1'b1) n_swr++;
      if (abrt === 1'b1) n_abt++;
   end
   task automatic chk(input logic ok, input string m);
      checks_done++;
      if (ok !== 1'b1) begin
         n_fail++;
         $display("[ERR] %0t %s", $time, m);
      end
   endtask : chk
   // one command, answer judged a cycle later
   task automatic issue(input fsr_cls_t c, input logic [9:0] s, input logic a);
      @(negedge clk);
      cmd_valid = 1'b1;
      cmd = '{cls: c, sector: s, page: 8'h03};
      @(negedge clk);
      cmd_valid = 1'b0;
      chk(a ? acc === 1'b1 : rej === 1'b1, "answer");
   endtask : issue
   task automatic finish_op();
      @(negedge clk);
      op_done = 1'b1;
      @(negedge clk);
      op_done = 1'b0;
   endtask : finish_op
   task automatic wait_st(input fsr_state_t t);
      n = 0;
      while (state !== t && n < 5000) begin
         @(negedge clk);
         n++;
      end
      chk(state === t, "state wait");
   endtask : wait_st
   // plain program, busy refusals, idle resume
   task automatic t_prog();
      issue(CL_PROG, 10'h004, 1'b1);
      chk(go === 1'b1 && wip === 1'b1 && flags[FL_PEC] === 1'b0, "start");
      issue(CL_READ, 10'h000, 1'b0);
      issue(CL_WVOL, 10'h000, 1'b0);
      issue(CL_RDSR, 10'h000, 1'b1);
      finish_op();
      chk(state === ST_STANDBY && flags === FLAG_RST, "done");
      issue(CL_RESUME, 10'h000, 1'b0);
      issue(CL_SUSP, 10'h000, 1'b0);
      chk(flags === FLAG_RST && state === ST_STANDBY, "idle");
      $display("test prog done");
   endtask : t_prog
   // program suspend, allowed commands, resume
   task automatic t_psusp();
      issue(CL_PROG, 10'h007, 1'b1);
      issue(CL_SUSP, 10'h000, 1'b1);
      chk(susp === 1'b1 && flags[FL_PRG_SUSP] === 1'b1, "susp");
      wait_st(ST_PSUSP);
      chk(n == PRG_SUSP_LAT_US * CLK_MHZ && wip === 1'b0, "lat");
      issue(CL_READ, 10'h009, 1'b1);
      chk(unsure === 1'b0, "other page");
      issue(CL_READ, 10'h007, 1'b1);
      chk(unsure === 1'b1, "own page");
      issue(CL_PROG, 10'h009, 1'b0);
      issue(CL_WVOL, 10'h000, 1'b1);
      issue(CL_SUSP, 10'h000, 1'b0);
      issue(CL_RESUME, 10'h000, 1'b1);
      chk(op.resumed === 1'b1 && wip === 1'b1 && flags === 8'h00, "res");
      finish_op();
      chk(flags === FLAG_RST, "end");
      issue(CL_PROG, 10'h001, 1'b1);
      issue(CL_SUSP, 10'h000, 1'b1);
      repeat (100) @(negedge clk);
      finish_op();
      chk(state === ST_STANDBY && flags === FLAG_RST, "early");
      $display("test psusp done");
   endtask : t_psusp
   // erase suspend with nested program suspend
   task automatic t_nest();
      issue(CL_SERASE, 10'h005, 1'b1);
      issue(CL_SUSP, 10'h000, 1'b1);
      chk(flags[FL_ERS_SUSP] === 1'b1, "esusp");
      wait_st(ST_ESUSP);
      chk(n == ERS_SUSP_LAT_US * CLK_MHZ && flags[FL_PEC] === 1'b1, "lat");
      issue(CL_READ, 10'h005, 1'b1);
      chk(unsure === 1'b1, "unsure");
      issue(CL_SERASE, 10'h006, 1'b0);
      issue(CL_SSE, 10'h006, 1'b0);
      issue(CL_WREG, 10'h006, 1'b0);
      issue(CL_WNV, 10'h006, 1'b0);
      issue(CL_CLRFL, 10'h006, 1'b1);
      issue(CL_PROG, 10'h005, 1'b0);
      chk(flags[FL_PRG_ERR] === 1'b1 && go === 1'b0, "err");
      issue(CL_PROG, 10'h006, 1'b1);
      issue(CL_SUSP, 10'h000, 1'b1);
      wait_st(ST_PSUSP);
      issue(CL_RESUME, 10'h000, 1'b1);
      chk(op.kind === OP_PROG && op.sector === 10'h006, "inner");
      finish_op();
      chk(state === ST_ESUSP, "back");
      issue(CL_RESUME, 10'h000, 1'b1);
      chk(op.kind === OP_ERASE && op.sector === 10'h005, "outer");
      finish_op();
      chk(state === ST_STANDBY && flags[FL_PEC] === 1'b1, "fin");
      issue(CL_CLRFL, 10'h000, 1'b1);
      $display("test nest done");
   endtask : t_nest
   // subsector erase suspend, one-time write start
   task automatic t_sse();
      issue(CL_SSE, 10'h00a, 1'b1);
      repeat (50 * CLK_MHZ) @(negedge clk);
      issue(CL_SUSP, 10'h000, 1'b1);
      chk(susp === 1'b1 && flags[FL_ERS_SUSP] === 1'b1, "sse susp");
      wait_st(ST_PSUSP);
      chk(n == ERS_SUSP_LAT_US * CLK_MHZ && wip === 1'b0, "sse lat");
      issue(CL_READ, 10'h00a, 1'b1);
      chk(unsure === 1'b1, "sse unsure");
      issue(CL_RDSR, 10'h000, 1'b1);
      issue(CL_OTHER, 10'h000, 1'b1);
      issue(CL_PROG, 10'h001, 1'b0);
      issue(CL_RESUME, 10'h000, 1'b1);
      chk(op.kind === OP_SSE && flags === 8'h00, "sse res");
      finish_op();
      chk(state === ST_STANDBY && flags === FLAG_RST, "sse end");
      issue(CL_WNV, 10'h000, 1'b1);
      chk(op.kind === OP_WNV && go === 1'b1, "wnv");
      finish_op();
      $display("test sse done");
   endtask : t_sse
   // software reset pair over the link
   task automatic t_reset();
      issue(CL_SERASE, 10'h003, 1'b1);
      n_swr = 0;
      n_abt = 0;
      u_host.reset_pair(8'h98);
      chk(n_swr == 0 && state === ST_BUSY, "bad pair");
      u_host.reset_pair(8'h99);
      chk(n_swr == 1 && n_abt == 1 && state === ST_STANDBY, "rst");
      chk(flags === FLAG_RST && wip === 1'b0, "flags");
      issue(CL_WREG, 10'h000, 1'b1);
      u_host.reset_pair(8'h99);
      chk(n_swr == 1 && state === ST_BUSY, "wreg");
      finish_op();
      $display("test reset done");
   endtask : t_reset
   task automatic results();
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : results
   // main sequence and watchdog
   initial begin
      rst_n = 1'b0;
      cmd_valid = 1'b0;
      cmd = '0;
      op_done = 1'b0;
      repeat (2) @(posedge clk);
      @(negedge clk) rst_n = 1'b1;
      t_prog();
      t_psusp();
      t_nest();
      t_sse();
      t_reset();
      results();
   end
   initial begin
      #200000; // about twice the summed test time
      n_fail++;
      $display("[ERR] %0t watchdog", $time);
      results();
   end
endmodule : flash_suspend_resume_reset_tb
